// ### verilog/ahp_serial_port.sv
// serial register-access port of a sigma-delta converter, device side
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - mode 3: clock idles high, output launched on fall, input captured on rise
// - port defaults to 3-wire; four-wire select at 1 chooses 4-wire
// - output release delay select only matters in 3-wire operation
// - 4-wire: output tristated while select high, driven while select low
// - 3-wire: select low enables output until the release delay after a frame, select high tristates it
// - streaming readout enable at 1 sends conversion words continuously
// - ready-pin select 00 puts data-ready onto the interrupt pin
// - awake within 36 master clocks after standby exit write
module ahp_serial_port #(
	parameter int WAKE_CYCLES  = ahp_pkg::WAKE_CYCLES,
	parameter int RESET_CYCLES = ahp_pkg::RESET_CYCLES
) (
	// system clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// serial link
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        sdi,
	output var  logic        sdo,
	output var  logic        sdo_oe_n,
	// configuration
	input  wire logic        four_wire_select,
	input  wire logic        output_release_delay_sel,
	input  wire logic        streaming_readout_enable,
	input  wire logic        map_check_error_enable,
	input  wire logic [1:0]  ready_pin_sel,
	// synchronisation pin
	input  wire logic        sync_n,
	// conversion results
	input  wire logic        conv_valid,
	input  wire logic [15:0] conv_data,
	// indications and register writes
	output var  logic        data_ready_n,
	output var  logic        sync_req,
	output var  logic        soft_reset_busy,
	output var  logic        awake,
	output var  logic        wr_strobe,
	output var  logic [6:0]  wr_addr,
	output var  logic [7:0]  wr_data
);

	logic        link_rst_n;
	logic [15:0] tx_word;
	logic [15:0] rx_word;
	logic        rx_toggle;
	logic        start_toggle;
	logic [2:0]  rx_sync;
	logic [2:0]  st_sync;
	logic [1:0]  cs_sync;
	logic [1:0]  sn_sync;
	logic        frame_evt;
	logic        start_evt;
	logic        pending;
	logic        standby;
	logic        released;
	logic [1:0]  rel_cnt;
	logic [31:0] wake_cnt;
	logic [31:0] reset_cnt;
	logic [15:0] sync_cnt;
	logic [15:0] conv_hold;
	logic        is_write;
	logic [6:0]  f_addr;
	logic [7:0]  f_data;

	////////////////////////////////////////////////////////////////////////
	// link side; select only resets the frame counter in 4-wire operation
	assign link_rst_n = reset_n & ~(four_wire_select & cs_n);

	ahp_link u_link (
		.sclk         (sclk),
		.link_rst_n   (link_rst_n),
		.sys_rst_n    (reset_n),
		.sdi          (sdi),
		.sdo          (sdo),
		.tx_word      (tx_word),
		.rx_word      (rx_word),
		.rx_toggle    (rx_toggle),
		.start_toggle (start_toggle)
	);

	////////////////////////////////////////////////////////////////////////
	// synchronisers for pins and link toggles
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_sync <= '0;
			st_sync <= '0;
			cs_sync <= 2'h3;
			sn_sync <= 2'h3;
		end else begin
			rx_sync <= {rx_sync[1:0], rx_toggle};
			st_sync <= {st_sync[1:0], start_toggle};
			cs_sync <= {cs_sync[0], cs_n};
			sn_sync <= {sn_sync[0], sync_n};
		end
	end

	assign frame_evt = rx_sync[2] ^ rx_sync[1];
	assign start_evt = st_sync[2] ^ st_sync[1];
	// rx_word stands still for a whole frame after its toggle
	assign is_write  = !rx_word[ahp_pkg::RW_BIT];
	assign f_addr    = rx_word[ahp_pkg::ADDR_MSB:ahp_pkg::ADDR_LSB];
	assign f_data    = rx_word[7:0];

	////////////////////////////////////////////////////////////////////////
	// output driver release after a 3-wire frame
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			released <= 1'b0;
			rel_cnt  <= '0;
		end else if (four_wire_select) begin
			released <= 1'b0;
			rel_cnt  <= '0;
		end else if (start_evt) begin
			released <= 1'b0;
			rel_cnt  <= '0;
		end else if (frame_evt) begin
			rel_cnt <= output_release_delay_sel
				? 2'(ahp_pkg::REL_DEL1_CYCLES)
				: 2'(ahp_pkg::REL_DEL0_CYCLES);
		end else if (rel_cnt != '0) begin
			rel_cnt <= rel_cnt - 2'h1;
			if (rel_cnt == 2'h1)
				released <= 1'b1;
		end
	end

	// select gates the driver in both modes
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			sdo_oe_n <= ahp_pkg::OE_OFF;
		else
			sdo_oe_n <= cs_sync[1]
				| (released & !four_wire_select);
	end

	////////////////////////////////////////////////////////////////////////
	// frame decode: register writes, standby and software reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_strobe <= 1'b0;
			wr_addr   <= '0;
			wr_data   <= '0;
			standby   <= 1'b0;
		end else begin
			wr_strobe <= 1'b0;
			if (frame_evt && is_write && !soft_reset_busy
				&& !streaming_readout_enable) begin
				wr_strobe <= 1'b1;
				wr_addr   <= f_addr;
				wr_data   <= f_data;
				if (f_addr == ahp_pkg::ADDR_MODE)
					standby <= f_data[ahp_pkg::STBY_BIT];
			end
		end
	end

	// software reset keeps the port deaf for the host's wait
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			soft_reset_busy <= 1'b0;
			reset_cnt       <= '0;
		end else if (frame_evt && is_write && !soft_reset_busy
			&& f_addr == ahp_pkg::ADDR_RESET
			&& f_data == ahp_pkg::RESET_KEY) begin
			soft_reset_busy <= 1'b1;
			reset_cnt       <= 32'(RESET_CYCLES);
		end else if (reset_cnt != '0) begin
			reset_cnt <= reset_cnt - 32'h1;
			if (reset_cnt == 32'h1)
				soft_reset_busy <= 1'b0;
		end
	end

	// wake-up from standby, oscillator kept running throughout
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			awake    <= 1'b1;
			wake_cnt <= '0;
		end else if (standby) begin
			awake    <= 1'b0;
			wake_cnt <= 32'(WAKE_CYCLES);
		end else if (!awake) begin
			wake_cnt <= wake_cnt - 32'h1;
			if (wake_cnt <= 32'h1)
				awake <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// synchronisation request after a long enough low pulse
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_cnt <= '0;
			sync_req <= 1'b0;
		end else if (sn_sync[1]) begin
			sync_cnt <= '0;
			sync_req <= 1'b0;
		end else begin
			if (sync_cnt != 16'(ahp_pkg::SYNC_CYCLES))
				sync_cnt <= sync_cnt + 16'h1;
			sync_req <= sync_cnt >= 16'(ahp_pkg::SYNC_CYCLES - 1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data ready: set by a conversion, cleared when a frame reads it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			pending <= 1'b0;
		else if (conv_valid)
			pending <= 1'b1; // set wins over clear
		else if (frame_evt && (streaming_readout_enable || !is_write))
			pending <= 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			data_ready_n <= ahp_pkg::READY_N_IDLE;
		else
			data_ready_n <= !(pending
				&& ready_pin_sel == ahp_pkg::PIN_SEL_INT);
	end

	// outgoing word: conversion result when streaming, else status
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			conv_hold <= '0;
			tx_word   <= '0;
		end else begin
			if (conv_valid)
				conv_hold <= conv_data;
			if (streaming_readout_enable && conv_valid)
				tx_word <= conv_data;
			else if (streaming_readout_enable)
				tx_word <= conv_hold;
			else
				tx_word <= {12'h000, streaming_readout_enable, pending,
					soft_reset_busy, awake};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	chk_oe_four_wire: assert property (@(posedge clk) disable iff (!reset_n)
		four_wire_select && cs_sync[1] |=> sdo_oe_n)
		else $error("output driven while select high in 4-wire");
	chk_oe_four_low: assert property (@(posedge clk) disable iff (!reset_n)
		four_wire_select && !cs_sync[1] |=> !sdo_oe_n)
		else $error("release delay acted in 4-wire operation");
	chk_oe_three_wire: assert property (@(posedge clk) disable iff (!reset_n)
		!four_wire_select && cs_sync[1] |=> sdo_oe_n)
		else $error("output driven while select high in 3-wire");
	chk_ready_pin_off: assert property (@(posedge clk) disable iff (!reset_n)
		ready_pin_sel != ahp_pkg::PIN_SEL_INT |=> data_ready_n)
		else $error("ready shown on interrupt pin when not selected");
	chk_ready_pin_set: assert property (@(posedge clk) disable iff (!reset_n)
		conv_valid ##1 (!frame_evt && ready_pin_sel == ahp_pkg::PIN_SEL_INT)
		|=> !data_ready_n)
		else $error("data ready missing after conversion");
	chk_stream_word: assert property (@(posedge clk) disable iff (!reset_n)
		streaming_readout_enable && conv_valid
		|=> tx_word == $past(conv_data))
		else $error("streaming word not the new conversion");
	chk_wake_asleep: assert property (@(posedge clk) disable iff (!reset_n)
		standby |=> !awake)
		else $error("awake while in standby");
	chk_wake_bound: assert property (@(posedge clk) disable iff (!reset_n)
		!awake |-> wake_cnt <= 32'(WAKE_CYCLES))
		else $error("wake-up count beyond its bound");
	chk_reset_hold: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(soft_reset_busy) |-> reset_cnt == 32'(RESET_CYCLES)
		##1 soft_reset_busy[*3])
		else $error("software reset wait not loaded");
	chk_sync_width: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(sync_req) |-> !$past(sn_sync[1])
		&& sync_cnt == 16'(ahp_pkg::SYNC_CYCLES))
		else $error("sync recognised after too short a pulse");

	cov_write: cover property (@(posedge clk) disable iff (!reset_n)
		wr_strobe);
	cov_stream: cover property (@(posedge clk) disable iff (!reset_n)
		streaming_readout_enable && frame_evt);
	cov_wake: cover property (@(posedge clk) disable iff (!reset_n)
		$rose(awake));
	cov_sync: cover property (@(posedge clk) disable iff (!reset_n)
		sync_req);

endmodule : ahp_serial_port
`default_nettype wire

// ### common/ahp_pkg.sv
// constants shared by the serial host port and its link shifter
package ahp_pkg;

	////////////////////////////////////////////////////////////////////////
	// frame layout
	localparam int          FRAME_BITS = 16;
	localparam int          CNT_W      = 4;
	localparam logic [3:0]  LAST_BIT   = 4'hF;
	localparam int          RW_BIT     = 15;   // 1 = read, 0 = write
	localparam int          ADDR_MSB   = 14;
	localparam int          ADDR_LSB   = 8;
	localparam logic [6:0]  ADDR_MODE  = 7'h01; // power mode word
	localparam logic [6:0]  ADDR_RESET = 7'h7F; // software reset word
	localparam logic [7:0]  RESET_KEY  = 8'hFF;
	localparam int          STBY_BIT   = 0;    // mode data bit: 1 = standby

	////////////////////////////////////////////////////////////////////////
	// status word bit positions
	localparam int          ST_AWAKE   = 0;
	localparam int          ST_RST     = 1;
	localparam int          ST_RDY     = 2;
	localparam int          ST_STREAM  = 3;

	////////////////////////////////////////////////////////////////////////
	// pin selection and reset values
	localparam logic [1:0]  PIN_SEL_INT  = 2'h0;
	localparam logic        OE_OFF       = 1'b1;
	localparam logic        READY_N_IDLE = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// timing, clocked by clk at 10 MHz; master clock at 76.8 kHz
	localparam int CLK_HZ          = 10_000_000;
	localparam int CLK_PERIOD_NS   = 100;
	localparam int MCLK_HZ         = 76_800;
	localparam int HZ_SCALE        = 100;
	localparam int SYNC_PW_MCLK    = 4;
	localparam int WAKE_MCLK       = 36;
	localparam int RESET_MCLK      = 1920;
	localparam int RESET_COLD_MCLK = 11550;
	localparam int REL_DEL0_NS     = 10;
	localparam int REL_DEL1_NS     = 100;
	// least times round up, longest times round down
	localparam int SYNC_CYCLES = (SYNC_PW_MCLK * (CLK_HZ / HZ_SCALE)
		+ MCLK_HZ / HZ_SCALE - 1) / (MCLK_HZ / HZ_SCALE);
	localparam int WAKE_CYCLES = (WAKE_MCLK * (CLK_HZ / HZ_SCALE))
		/ (MCLK_HZ / HZ_SCALE);
	localparam int RESET_CYCLES = (RESET_MCLK * (CLK_HZ / HZ_SCALE)
		+ MCLK_HZ / HZ_SCALE - 1) / (MCLK_HZ / HZ_SCALE);
	localparam int RESET_COLD_CYCLES = (RESET_COLD_MCLK
		* (CLK_HZ / HZ_SCALE) + MCLK_HZ / HZ_SCALE - 1)
		/ (MCLK_HZ / HZ_SCALE);
	localparam int REL_DEL0_CYCLES = (REL_DEL0_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int REL_DEL1_CYCLES = (REL_DEL1_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

endpackage : ahp_pkg

// ### verilog/ahp_link.sv
// link-side shifter of the serial host port, clocked by the serial clock
`timescale 1ns/1ps
`default_nettype none
module ahp_link (
	// link clock, frame reset and system reset
	input  wire logic        sclk,
	input  wire logic        link_rst_n,
	input  wire logic        sys_rst_n,
	// serial data
	input  wire logic        sdi,
	output var  logic        sdo,
	// words to and from the system side
	input  wire logic [15:0] tx_word,
	output var  logic [15:0] rx_word,
	output var  logic        rx_toggle,
	output var  logic        start_toggle
);

	logic [ahp_pkg::CNT_W-1:0]      bit_cnt;
	logic [ahp_pkg::FRAME_BITS-1:0] shift_in;
	logic [ahp_pkg::FRAME_BITS-1:0] shift_out;

	////////////////////////////////////////////////////////////////////////
	// capture on rising edges, frame ends after sixteen edges
	always_ff @(posedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt  <= '0;
			shift_in <= '0;
		end else begin
			bit_cnt  <= bit_cnt + 4'h1;
			shift_in <= {shift_in[14:0], sdi};
		end
	end

	// finished word and its toggle survive the select rising after a frame
	always_ff @(posedge sclk or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			rx_word   <= '0;
			rx_toggle <= 1'b0;
		end else if (bit_cnt == ahp_pkg::LAST_BIT) begin
			rx_word   <= {shift_in[14:0], sdi};
			rx_toggle <= ~rx_toggle;
		end
	end

	// marks the first rising edge of a frame
	always_ff @(posedge sclk or negedge sys_rst_n) begin
		if (!sys_rst_n)
			start_toggle <= 1'b0;
		else if (bit_cnt == '0)
			start_toggle <= ~start_toggle;
	end

	////////////////////////////////////////////////////////////////////////
	// launch on falling edges, word loaded on the frame's first fall
	always_ff @(negedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			shift_out <= '0;
			sdo       <= 1'b0;
		end else if (bit_cnt == '0) begin
			shift_out <= {tx_word[14:0], 1'b0};
			sdo       <= tx_word[15];
		end else begin
			shift_out <= {shift_out[14:0], 1'b0};
			sdo       <= shift_out[15];
		end
	end

endmodule : ahp_link
`default_nettype wire

// ### test/ahp_host_model.sv
// host controller model driving the serial link in mode 3
`timescale 1ns/1ps
`default_nettype none
module ahp_host_model (
	// serial link
	output var  logic sclk,
	output var  logic cs_n,
	output var  logic sdi,
	input  wire logic sdo,
	input  wire logic sdo_oe_n
);
	////////////////////////////////////////////////////////////////////////
	// clock idles high, select released, data at a fixed start level
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		sdi  = 1'b0;
	end

	// hold select at a level of the bench's choosing between frames
	task automatic tie_cs(input logic v);
		cs_n = v;
	endtask : tie_cs

	// one 16-bit frame; data out on fall, sampled in on rise
	task automatic frame(input logic [15:0] tx, input logic use_cs,
		output logic [15:0] rx);
		if (use_cs)
			cs_n = 1'b0;
		#300; // driver enable crosses three system flops first
		for (int i = 15; i >= 0; i--) begin
			#24 sclk = 1'b0;
			sdi = tx[i];
			#24 sclk = 1'b1;
			rx[i] = sdo_oe_n ? ~sdo : sdo; // undriven line reads inverted
		end
		#10 sdi = ~sdi; // released line shows no stale value
		if (use_cs)
			cs_n = 1'b1;
	endtask : frame
endmodule : ahp_host_model
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the serial host port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int WAKE_P  = 20;
	localparam int RESET_P = 40;
	localparam int SYNC_C  = ahp_pkg::SYNC_CYCLES;

	logic        clk, reset_n, sclk, cs_n, sdi, sdo, sdo_oe_n;
	logic        fws, rel_sel, sre, mce, sync_n, conv_valid;
	logic [1:0]  pin_sel;
	logic [15:0] conv_data, rx;
	logic        data_ready_n, sync_req, soft_reset_busy, awake;
	logic        wr_strobe, mo, sn;
	logic [6:0]  wr_addr;
	logic [7:0]  wr_data;
	int          fail_count, samples_checked, n;

	////////////////////////////////////////////////////////////////////////
	// design and host model
	ahp_serial_port #(.WAKE_CYCLES(WAKE_P), .RESET_CYCLES(RESET_P))
		ahp_serial_port_i (.clk(clk), .reset_n(reset_n), .sclk(sclk),
		.cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
		.four_wire_select(fws), .output_release_delay_sel(rel_sel),
		.streaming_readout_enable(sre), .map_check_error_enable(mce),
		.ready_pin_sel(pin_sel), .sync_n(sync_n),
		.conv_valid(conv_valid), .conv_data(conv_data),
		.data_ready_n(data_ready_n), .sync_req(sync_req),
		.soft_reset_busy(soft_reset_busy), .awake(awake),
		.wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));
	ahp_host_model ahp_host_model_i (.sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.sdo(sdo), .sdo_oe_n(sdo_oe_n));

	// system clock
	initial clk = 1'b0;
	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	// compare, verdict and transfer helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t %s", $time, what);
		end
	endtask : chk

	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	// frame with mid-frame enable sample and write strobe watch
	task automatic xfer(input logic [15:0] w, input logic cs);
		sn = 1'b0;
		fork
			ahp_host_model_i.frame(w, cs, rx);
			begin
				repeat (8) @(negedge clk);
				mo = sdo_oe_n;
			end
		join
		repeat (8) begin
			@(negedge clk);
			if (wr_strobe === 1'b1)
				sn = 1'b1;
		end
	endtask : xfer

	// one-cycle conversion pulse
	task automatic conv(input logic [15:0] d);
		@(negedge clk);
		conv_valid = 1'b1;
		conv_data  = d;
		@(negedge clk);
		conv_valid = 1'b0;
		repeat (2) @(negedge clk);
	endtask : conv

	// hang guard
	initial begin
		#3_000_000;
		fail_count++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////
	// test sequence
	initial begin
		{reset_n, fws, rel_sel, sre, mce, conv_valid} = 6'h00;
		{sync_n, pin_sel, conv_data} = {1'b1, 2'h0, 16'h0000};
		fail_count = 0;
		samples_checked = 0;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		repeat (3) @(negedge clk);
		chk(16'({sdo_oe_n, data_ready_n, sync_req, soft_reset_busy, awake,
			wr_strobe}), 16'h0032, "reset levels");
		// 4-wire write and status read
		fws = 1'b1;
		xfer(16'h05A5, 1'b1);
		chk(16'({sn, wr_addr, wr_data}), 16'h85A5, "write 4w");
		chk(16'({mo, sdo_oe_n}), 16'h0001, "enable 4w");
		xfer(16'h8000, 1'b1);
		chk(rx, 16'h0001, "status read");
		// 3-wire, select high then tied low, both release settings
		fws = 1'b0;
		for (int d = 0; d < 2; d++) begin
			rel_sel = d[0];
			xfer(16'h053C, 1'b0);
			chk(16'({sn, mo, wr_data}), 16'h033C, "3w high");
			ahp_host_model_i.tie_cs(1'b0);
			@(negedge clk);
			xfer(16'h06C3, 1'b0);
			xfer(16'h0781, 1'b0);
			chk(16'({sn, mo, sdo_oe_n, wr_addr}), 16'h0287, "3w tied");
			chk(16'(wr_data), 16'h0081, "3w tied data");
			ahp_host_model_i.tie_cs(1'b1);
		end
		// data ready on the interrupt pin
		fws = 1'b1;
		conv(16'h1234);
		chk(16'(data_ready_n), 16'h0000, "ready low");
		xfer(16'h8000, 1'b1);
		chk(rx, 16'h0005, "ready pending");
		chk(16'(data_ready_n), 16'h0001, "ready cleared");
		pin_sel = 2'h1;
		conv(16'h4321);
		repeat (2) @(negedge clk);
		chk(16'(data_ready_n), 16'h0001, "ready other pin");
		pin_sel = 2'h0;
		// streaming readout, writes refused
		sre = 1'b1;
		conv(16'h5A3C);
		xfer(16'h8000, 1'b1);
		chk(rx, 16'h5A3C, "stream word");
		xfer(16'h0577, 1'b1);
		chk(16'(sn), 16'h0000, "write in stream");
		sre = 1'b0;
		xfer(16'h8000, 1'b1);
		// standby and wake-up, with inter-write gap
		mce = 1'b1;
		xfer(16'h0101, 1'b1);
		chk(16'(awake), 16'h0000, "standby");
		#45_000;
		xfer(16'h0100, 1'b1);
		chk(16'(awake), 16'h0000, "waking");
		n = 0;
		while (awake !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk(16'(n <= WAKE_P), 16'h0001, "wake time");
		mce = 1'b0;
		// software reset, refused write, host waits
		xfer(16'h7FFF, 1'b1);
		chk(16'(soft_reset_busy), 16'h0001, "reset busy");
		xfer(16'h0511, 1'b1);
		chk(16'({sn, soft_reset_busy}), 16'h0001, "write in reset");
		n = 0;
		while (soft_reset_busy !== 1'b0 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk(16'(n <= RESET_P), 16'h0001, "reset length");
		xfer(16'h0522, 1'b1);
		chk(16'({sn, wr_data}), 16'h0122, "write after reset");
		// sync: short pulse ignored, long pulse seen and held
		sync_n = 1'b0;
		repeat (SYNC_C - 10) @(negedge clk);
		chk(16'(sync_req), 16'h0000, "short sync");
		sync_n = 1'b1;
		repeat (5) @(negedge clk);
		sync_n = 1'b0;
		n = 0;
		while (sync_req !== 1'b1 && n < 700) begin
			@(negedge clk);
			n++;
		end
		chk(16'(n >= SYNC_C && n <= SYNC_C + 4), 16'h0001, "sync");
		repeat (2) @(negedge clk);
		chk(16'(sync_req), 16'h0001, "sync held");
		sync_n = 1'b1;
		repeat (4) @(negedge clk);
		chk(16'(sync_req), 16'h0000, "sync end");
		conclude();
	end
endmodule : tb_top
`default_nettype wire
